// ===== rsse_pkg.sv
`default_nettype none
package rsse_pkg;

	// ==========================================================
	// register offsets
	localparam logic [7:0]  ADDR_INSTR     = 8'h00;
	localparam logic [7:0]  ADDR_WREG      = 8'h04;
	localparam logic [7:0]  ADDR_STATUS    = 8'h08;
	localparam logic [7:0]  ADDR_BANK      = 8'h0C;
	localparam logic [7:0]  ADDR_CFG       = 8'h10;
	localparam logic [7:0]  ADDR_MADDR     = 8'h14;
	localparam logic [7:0]  ADDR_MDATA     = 8'h18;

	// ==========================================================
	// instruction encodings
	localparam logic [5:0]  OPC_ROT        = 6'h10;
	localparam logic [6:0]  OPC_SET        = 7'h34;
	localparam logic [5:0]  OPC_SUB        = 6'h15;
	localparam logic [15:0] SLEEP_WORD     = 16'h0003;
	localparam logic [7:0]  ALL_ONES       = 8'hFF;

	// ==========================================================
	// operand addressing
	localparam logic [7:0]  ACCESS_LIMIT   = 8'h5F;
	localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
	localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
	localparam int          CFG_EXT_BIT    = 12;

	// ==========================================================
	// status read-word fields (flags byte plus busy and sleep bits) and reset values
	localparam int          ST_C           = 0;
	localparam int          ST_DC          = 1;
	localparam int          ST_Z           = 2;
	localparam int          ST_OV          = 3;
	localparam int          ST_N           = 4;
	localparam int          ST_PWRDN       = 5;
	localparam int          ST_EXPIRY      = 6;
	localparam int          ST_BUSY        = 8;
	localparam int          ST_SLEEP       = 9;
	localparam logic [7:0]  STATUS_RESET   = 8'h60;
	localparam logic [7:0]  STATUS_WMASK   = 8'h1F;

	typedef enum logic [2:0] {
		PH_IDLE  = 3'b000,
		PH_Q1    = 3'b001,
		PH_Q2    = 3'b010,
		PH_Q3    = 3'b011,
		PH_Q4    = 3'b100,
		PH_SLEEP = 3'b101
	} rsse_phase_t;

	typedef enum logic [2:0] {
		OP_NOP   = 3'b000,
		OP_ROT   = 3'b001,
		OP_SET   = 3'b010,
		OP_SUB   = 3'b011,
		OP_SLEEP = 3'b100
	} rsse_op_t;

	typedef struct packed {
		rsse_op_t    op;
		logic        to_mem;
		logic        asel;
		logic [7:0]  f;
	} rsse_decode_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} rsse_bus_t;

endpackage : rsse_pkg
`default_nettype wire

// ===== rsse_core.sv
// What this block does
// - rotate right with destination set writes the result back to the operand register
// - rotate right with destination clear writes the result to the accumulator only
// - set-all-ones writes FFh to the operand, no flags change, opcode 0110 100a
// - select bit clear picks the access bank, set picks the bank pointer's bank
// - select clear with extended set enabled: indexed offset addressing up to 5Fh
// - sleep clears the watchdog counter and its postscaler
// - sleep clears the powerdown flag and sets the expiry flag, nothing else
// - sleep word 0003h halts the oscillator, entered in the fourth phase
// - a watchdog wake-up from sleep clears the expiry flag
// - subtract with borrow: accumulator minus operand minus inverted carry to destination
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rsse_core (
	input  wire logic              CLOCK_IN,
	input  wire logic              RST_IN,
	input  wire rsse_pkg::rsse_bus_t BUS_IN,
	input  wire logic              WATCHDOG_WAKE_IN,
	output logic [15:0]            RDATA_OUT,
	output logic                   SLEEP_OUT,
	output logic                   WATCHDOG_CLEAR_OUT,
	output logic                   BUSY_OUT
);
	import rsse_pkg::*;

	// ==========================================================
	// functions
	function automatic rsse_decode_t decode_word(input logic [15:0] w);
		rsse_decode_t d;
		d.op     = OP_NOP;
		d.to_mem = w[9];
		d.asel   = w[8];
		d.f      = w[7:0];
		if (w == SLEEP_WORD) begin
			d.op = OP_SLEEP;
		end else if (w[15:10] == OPC_ROT) begin
			d.op = OP_ROT;
		end else if (w[15:9] == OPC_SET) begin
			d.op     = OP_SET;
			d.to_mem = 1'b1;
		end else if (w[15:10] == OPC_SUB) begin
			d.op = OP_SUB;
		end
		return d;
	endfunction : decode_word

	function automatic logic [11:0] eff_addr(input rsse_decode_t d, input logic [3:0] bank,
		input logic ext, input logic [11:0] base);
		if (!d.asel && ext && d.f <= ACCESS_LIMIT) begin
			eff_addr = base + {4'h0, d.f};
		end else if (!d.asel) begin
			eff_addr = {(d.f <= ACCESS_LIMIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK, d.f};
		end else begin
			eff_addr = {bank, d.f};
		end
	endfunction : eff_addr

	// returns {negative, zero}
	function automatic logic [1:0] nz_of(input logic [7:0] v);
		nz_of = {v[7], v == 8'h00};
	endfunction : nz_of

	// ==========================================================
	// state
	logic [7:0]   mem [0:4095];
	rsse_phase_t  phase_ff,  nxt_phase;
	rsse_decode_t dec_ff,    nxt_dec;
	logic [15:0]  instr_ff,  nxt_instr;
	logic [11:0]  ea_ff,     nxt_ea;
	logic [7:0]   opnd_ff,   nxt_opnd;
	logic [7:0]   res_ff,    nxt_res;
	logic [4:0]   flg_ff,    nxt_flg;
	logic [7:0]   w_ff,      nxt_w;
	logic [7:0]   status_ff, nxt_status;
	logic [3:0]   bank_ff,   nxt_bank;
	logic [12:0]  cfg_ff,    nxt_cfg;
	logic [11:0]  maddr_ff,  nxt_maddr;
	logic [15:0]  rdata_ff,  nxt_rdata;
	logic         wclr_ff,   nxt_wclr;
	logic         wake_s1_ff;
	logic         wake_s2_ff;
	logic         mem_we;
	logic [11:0]  mem_wa;
	logic [7:0]   mem_wd;
	logic [8:0]   diff;
	logic [4:0]   nib;
	logic [7:0]   rot;

	// ==========================================================
	// arithmetic: carry set means no borrow
	assign diff = {1'b0, w_ff} + {1'b0, ~opnd_ff} + {8'h00, status_ff[ST_C]};
	assign nib  = {1'b0, w_ff[3:0]} + {1'b0, ~opnd_ff[3:0]} + {4'h0, status_ff[ST_C]};
	assign rot  = {opnd_ff[0], opnd_ff[7:1]};

	always_comb begin
		nxt_phase  = phase_ff;
		nxt_dec    = dec_ff;
		nxt_instr  = instr_ff;
		nxt_ea     = ea_ff;
		nxt_opnd   = opnd_ff;
		nxt_res    = res_ff;
		nxt_flg    = flg_ff;
		nxt_w      = w_ff;
		nxt_status = status_ff;
		nxt_bank   = bank_ff;
		nxt_cfg    = cfg_ff;
		nxt_maddr  = maddr_ff;
		nxt_wclr   = 1'b0;
		nxt_rdata  = 16'h0000;
		mem_we     = 1'b0;
		mem_wa     = maddr_ff;
		mem_wd     = BUS_IN.wdata[7:0];
		if (BUS_IN.rd) begin
			unique case (BUS_IN.addr)
				ADDR_INSTR:  nxt_rdata = instr_ff;
				ADDR_WREG:   nxt_rdata = {8'h00, w_ff};
				ADDR_STATUS: nxt_rdata = {6'h00, phase_ff == PH_SLEEP,
					phase_ff != PH_IDLE, status_ff};
				ADDR_BANK:   nxt_rdata = {12'h000, bank_ff};
				ADDR_CFG:    nxt_rdata = {3'h0, cfg_ff};
				ADDR_MADDR:  nxt_rdata = {4'h0, maddr_ff};
				ADDR_MDATA:  nxt_rdata = {8'h00, mem[maddr_ff]};
				default:     nxt_rdata = 16'h0000;
			endcase
		end
		unique case (phase_ff)
			PH_IDLE: begin
				// software writes land only between instructions
				if (BUS_IN.wr) begin
					unique case (BUS_IN.addr)
						ADDR_INSTR: begin
							nxt_instr = BUS_IN.wdata;
							nxt_phase = PH_Q1;
						end
						ADDR_WREG:   nxt_w = BUS_IN.wdata[7:0];
						ADDR_STATUS: nxt_status = (status_ff & ~STATUS_WMASK)
							| (BUS_IN.wdata[7:0] & STATUS_WMASK);
						ADDR_BANK:   nxt_bank = BUS_IN.wdata[3:0];
						ADDR_CFG:    nxt_cfg = BUS_IN.wdata[12:0];
						ADDR_MADDR:  nxt_maddr = BUS_IN.wdata[11:0];
						ADDR_MDATA:  mem_we = 1'b1;
						default:     nxt_phase = PH_IDLE;
					endcase
				end
			end
			PH_Q1: begin
				nxt_dec   = decode_word(instr_ff);
				nxt_ea    = eff_addr(decode_word(instr_ff), bank_ff, cfg_ff[CFG_EXT_BIT],
					cfg_ff[11:0]);
				nxt_phase = PH_Q2;
			end
			PH_Q2: begin
				nxt_opnd  = mem[ea_ff];
				nxt_phase = PH_Q3;
			end
			PH_Q3: begin
				nxt_flg   = status_ff[4:0];
				nxt_res   = opnd_ff;
				unique case (dec_ff.op)
					OP_ROT: begin
						nxt_res = rot;
						{nxt_flg[ST_N], nxt_flg[ST_Z]} = nz_of(rot);
					end
					OP_SET:  nxt_res = ALL_ONES;
					OP_SUB: begin
						nxt_res         = diff[7:0];
						{nxt_flg[ST_N], nxt_flg[ST_Z]} = nz_of(diff[7:0]);
						nxt_flg[ST_C]   = diff[8];
						nxt_flg[ST_DC]  = nib[4];
						nxt_flg[ST_OV]  = (w_ff[7] != opnd_ff[7]) && (diff[7] != w_ff[7]);
					end
					default: nxt_res = opnd_ff;
				endcase
				nxt_phase = PH_Q4;
			end
			PH_Q4: begin
				nxt_phase = PH_IDLE;
				if (dec_ff.op == OP_SLEEP) begin
					nxt_status[ST_EXPIRY] = 1'b1;
					nxt_status[ST_PWRDN]  = 1'b0;
					nxt_wclr  = 1'b1;
					nxt_phase = PH_SLEEP;
				end else if (dec_ff.op != OP_NOP) begin
					nxt_status[4:0] = flg_ff;
					if (dec_ff.to_mem) begin
						mem_we = 1'b1;
						mem_wa = ea_ff;
						mem_wd = res_ff;
					end else begin
						nxt_w = res_ff;
					end
				end
			end
			PH_SLEEP: begin
				if (wake_s2_ff) begin
					nxt_status[ST_EXPIRY] = 1'b0;
					nxt_phase = PH_IDLE;
				end
			end
			default: nxt_phase = PH_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			phase_ff   <= PH_IDLE;
			dec_ff     <= '0;
			instr_ff   <= 16'h0000;
			ea_ff      <= 12'h000;
			opnd_ff    <= 8'h00;
			res_ff     <= 8'h00;
			flg_ff     <= 5'h00;
			w_ff       <= 8'h00;
			status_ff  <= STATUS_RESET;
			bank_ff    <= 4'h0;
			cfg_ff     <= 13'h0000;
			maddr_ff   <= 12'h000;
			rdata_ff   <= 16'h0000;
			wclr_ff    <= 1'b0;
			wake_s1_ff <= 1'b0;
			wake_s2_ff <= 1'b0;
		end else begin
			phase_ff   <= nxt_phase;
			dec_ff     <= nxt_dec;
			instr_ff   <= nxt_instr;
			ea_ff      <= nxt_ea;
			opnd_ff    <= nxt_opnd;
			res_ff     <= nxt_res;
			flg_ff     <= nxt_flg;
			w_ff       <= nxt_w;
			status_ff  <= nxt_status;
			bank_ff    <= nxt_bank;
			cfg_ff     <= nxt_cfg;
			maddr_ff   <= nxt_maddr;
			rdata_ff   <= nxt_rdata;
			wclr_ff    <= nxt_wclr;
			// watchdog expiry arrives from the halted-clock domain
			wake_s1_ff <= WATCHDOG_WAKE_IN;
			wake_s2_ff <= wake_s1_ff;
		end
	end

	// data memory is not reset: contents are undefined after power-up
	always_ff @(posedge CLOCK_IN) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	assign RDATA_OUT          = rdata_ff;
	assign SLEEP_OUT          = (phase_ff == PH_SLEEP);
	assign WATCHDOG_CLEAR_OUT = wclr_ff;
	assign BUSY_OUT           = (phase_ff != PH_IDLE);

	// ==========================================================
	// assertions
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);

	a_rot_writeback: assert property (
		phase_ff == PH_Q4 && dec_ff.op == OP_ROT && dec_ff.to_mem
		|=> mem[$past(ea_ff)] == {$past(opnd_ff[0]), $past(opnd_ff[7:1])})
		else $error("rotate result not written to operand");
	a_rot_to_accum: assert property (
		phase_ff == PH_Q3 && dec_ff.op == OP_ROT && !dec_ff.to_mem
		|=> ##1 w_ff == {$past(opnd_ff[0], 2), $past(opnd_ff[7:1], 2)})
		else $error("rotate result not placed in accumulator");
	a_set_ones: assert property (
		phase_ff == PH_Q4 && dec_ff.op == OP_SET
		|=> mem[$past(ea_ff)] == ALL_ONES && $stable(status_ff))
		else $error("set-all-ones wrong value or flags moved");
	a_bank_pick: assert property (
		phase_ff == PH_Q2 && dec_ff.asel |-> ea_ff == {bank_ff, dec_ff.f})
		else $error("bank pointer not used for operand");
	a_indexed_mode: assert property (
		phase_ff == PH_Q2 && !dec_ff.asel && cfg_ff[CFG_EXT_BIT] && dec_ff.f <= ACCESS_LIMIT
		|-> ea_ff == cfg_ff[11:0] + {4'h0, dec_ff.f})
		else $error("indexed offset address wrong");
	a_sleep_watchdog_clear: assert property (
		phase_ff == PH_Q4 && dec_ff.op == OP_SLEEP |=> WATCHDOG_CLEAR_OUT ##1 !WATCHDOG_CLEAR_OUT)
		else $error("watchdog clear pulse missing");
	a_sleep_flags: assert property (
		phase_ff == PH_Q4 && dec_ff.op == OP_SLEEP
		|=> status_ff[ST_EXPIRY] && !status_ff[ST_PWRDN] && status_ff[4:0] == $past(status_ff[4:0]))
		else $error("sleep flags wrong");
	a_sleep_entry: assert property (
		instr_ff == SLEEP_WORD && phase_ff == PH_Q1 |-> ##4 SLEEP_OUT)
		else $error("sleep not entered after fourth phase");
	a_wake_clears: assert property (
		SLEEP_OUT && wake_s2_ff |=> !status_ff[ST_EXPIRY] && !SLEEP_OUT)
		else $error("watchdog wake did not clear expiry flag");
	a_sub_borrow: assert property (
		phase_ff == PH_Q3 && dec_ff.op == OP_SUB && !dec_ff.to_mem
		|=> ##1 w_ff == 8'($past(w_ff, 2) - $past(opnd_ff, 2) - {7'h00, !$past(status_ff[ST_C], 2)}))
		else $error("subtract with borrow wrong");
	a_four_phases: assert property (
		phase_ff == PH_Q1 |=> phase_ff == PH_Q2 ##1 phase_ff == PH_Q3 ##1 phase_ff == PH_Q4)
		else $error("instruction cycle not four phases");

	c_rotate: cover property (phase_ff == PH_Q4 && dec_ff.op == OP_ROT);
	c_set:    cover property (phase_ff == PH_Q4 && dec_ff.op == OP_SET);
	c_sub:    cover property (phase_ff == PH_Q4 && dec_ff.op == OP_SUB && !flg_ff[ST_C]);
	c_wake:   cover property (SLEEP_OUT && wake_s2_ff);

endmodule : rsse_core
`default_nettype wire

// ===== rotate_set_sleep_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rotate_set_sleep_exec_tb;
	import rsse_pkg::*;

	// ==========================================================
	// clock, reset and stimulus
	logic        clk   = 1'b0;
	logic        rst   = 1'b1;
	logic        wake  = 1'b0;
	rsse_bus_t   bus   = '0;
	logic [15:0] rdata;
	logic        sleep;
	logic        wclr;
	logic        busy;
	int          n_mismatch   = 0;
	int          total_checks = 0;
	logic [15:0] v;

	always #2.5 clk = ~clk;

	rsse_core dut (
		.CLOCK_IN           (clk),
		.RST_IN             (rst),
		.BUS_IN             (bus),
		.WATCHDOG_WAKE_IN   (wake),
		.RDATA_OUT          (rdata),
		.SLEEP_OUT          (sleep),
		.WATCHDOG_CLEAR_OUT (wclr),
		.BUSY_OUT           (busy)
	);

	// ==========================================================
	// shared tasks
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic bw(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : bw

	// read data stand only in the cycle after the strobe
	task automatic br(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask : br

	task automatic mw(input logic [11:0] a, input logic [7:0] d);
		bw(ADDR_MADDR, {4'h0, a});
		bw(ADDR_MDATA, {8'h00, d});
	endtask : mw

	task automatic mr(input logic [11:0] a, output logic [15:0] d);
		bw(ADDR_MADDR, {4'h0, a});
		br(ADDR_MDATA, d);
	endtask : mr

	task automatic exec(input logic [15:0] w);
		int n;
		n = 0;
		bw(ADDR_INSTR, w);
		for (int i = 0; i < 20; i++) begin
			#1;
			if (busy !== 1'b1) break;
			n++;
			@(posedge clk);
		end
		if (n >= 20) begin
			n_mismatch++;
			end_of_test();
		end
		chk("busy cycles", 16'(n), 16'h0004);
	endtask : exec

	// ==========================================================
	// scenarios
	task automatic t_set();
		bw(ADDR_STATUS, 16'h0015);
		mw(12'hF80, 8'h5A);
		exec(16'h6880);
		mr(12'hF80, v);
		chk("set access hi", v, 16'h00FF);
		br(ADDR_STATUS, v);
		chk("set flags", {8'h00, v[7:0]}, 16'h0075);
		bw(ADDR_BANK, 16'h0002);
		mw(12'h244, 8'h00);
		exec(16'h6944);
		mr(12'h244, v);
		chk("set banked", v, 16'h00FF);
		bw(ADDR_CFG, 16'h1200);
		mw(12'h205, 8'h00);
		exec(16'h6805);
		mr(12'h205, v);
		chk("set indexed", v, 16'h00FF);
		bw(ADDR_CFG, 16'h0000);
	endtask : t_set

	task automatic t_rot();
		mw(12'h230, 8'hD7);
		exec(16'h4330);
		mr(12'h230, v);
		chk("rot to reg", v, 16'h00EB);
		br(ADDR_WREG, v);
		chk("rot w kept", v, 16'h0000);
		mw(12'h010, 8'hD7);
		exec(16'h4010);
		br(ADDR_WREG, v);
		chk("rot to w", v, 16'h00EB);
		mr(12'h010, v);
		chk("rot reg kept", v, 16'h00D7);
	endtask : t_rot

	task automatic t_sub();
		bw(ADDR_STATUS, 16'h0001);
		bw(ADDR_WREG, 16'h0002);
		mw(12'h020, 8'h03);
		exec(16'h5620);
		mr(12'h020, v);
		chk("sub to reg", v, 16'h00FF);
		br(ADDR_STATUS, v);
		chk("sub borrow", {15'h0000, v[ST_C]}, 16'h0000);
		bw(ADDR_WREG, 16'h0005);
		mw(12'h020, 8'h02);
		exec(16'h5420);
		br(ADDR_WREG, v);
		chk("sub to w", v, 16'h0002);
		// an unknown word still takes four phases and leaves the accumulator alone
		exec(16'hFFFF);
		br(ADDR_WREG, v);
		chk("nop w kept", v, 16'h0002);
	endtask : t_sub

	task automatic t_sleep();
		int n;
		n = 0;
		bw(ADDR_STATUS, 16'h000A);
		bw(ADDR_INSTR, SLEEP_WORD);
		for (int i = 0; i < 10; i++) begin
			#1;
			if (wclr === 1'b1) break;
			n++;
			@(posedge clk);
		end
		chk("sleep entry edge", 16'(n), 16'h0004);
		chk("sleep out", {15'h0000, sleep}, 16'h0001);
		@(posedge clk);
		#1 chk("watchdog clear pulse", {15'h0000, wclr}, 16'h0000);
		// writes are refused while asleep
		bw(ADDR_WREG, 16'h0077);
		br(ADDR_STATUS, v);
		chk("sleep flags", {8'h00, v[7:0]}, 16'h004A);
		@(posedge clk);
		wake <= 1'b1;
		n = 0;
		// sample after the edge has settled, not in the step that launches it
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			#1;
			if (sleep === 1'b0) break;
			n++;
		end
		if (n >= 10) begin
			n_mismatch++;
			end_of_test();
		end
		chk("wake latency", 16'(n), 16'h0002);
		@(posedge clk);
		wake <= 1'b0;
		br(ADDR_STATUS, v);
		chk("wake flags", {8'h00, v[7:0]}, 16'h000A);
		br(ADDR_WREG, v);
		chk("w after sleep", v, 16'h0002);
	endtask : t_sleep

	// ==========================================================
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		br(ADDR_STATUS, v);
		chk("status reset", v, {8'h00, STATUS_RESET});
		t_set();
		t_rot();
		t_sub();
		t_sleep();
		end_of_test();
	end

endmodule : rotate_set_sleep_exec_tb
`default_nettype wire
